// ---- dv/dcwsp_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Serial controller model, far side of the port
// ----------------------------------------------------------
module dcwsp_ctrl_model (
    input  wire logic core_clk_i,  // Core clock, frames start 1.25 ns after its fall
    input  wire logic chain_out_i, // Cascade output of the device
    output logic      select_o,    // Port select
    output logic      sclk_o,      // Serial clock, also toggled outside frames
    output logic      sdata_o      // Serial data
);
    logic loop_q; // Loop-back via feedback path
    logic drv_q;  // Level driven by controller
    // Released line follows the feedback path in loop mode
    assign sdata_o = loop_q ? chain_out_i : drv_q;
    initial begin
        select_o = 1'b0;
        sclk_o   = 1'b0;
        drv_q    = 1'b0;
        loop_q   = 1'b0;
    end
    // One 17-bit frame, stack bit first; 125 ns serial clock period,
    // phase kept clear of both core clock edges (pins are async)
    task automatic xfer(input logic [16:0] w, input logic lp, output logic [16:0] seen);
        @(negedge core_clk_i);
        #1.25;
        loop_q   = lp;
        select_o = 1'b1;
        for (int i = 16; i >= 0; i--) begin
            drv_q = w[i];
            #62.5;
            seen[i] = chain_out_i; // Settled bit before the rise
            sclk_o  = 1'b1;
            #62.5;
            sclk_o  = 1'b0;
        end
        #62.5;
        select_o = 1'b0;
        #62.5;
        loop_q = 1'b0;
        drv_q  = ~drv_q; // Undriven line: no stale value
        #62.5; // Select stays inactive before the next frame
    endtask : xfer
    // Clock pulses with select low, data toggling
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            drv_q = ~drv_q;
            #62.5;
            sclk_o = ~sclk_o;
        end
        #62.5;
    endtask : idle_clocks
endmodule : dcwsp_ctrl_model
`default_nettype wire

// ---- dv/dcwsp_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module dcwsp_tb_top;
    import dcwsp_pkg::*;
    logic               core_clk, rstn;       // Clock and reset
    logic               select, sclk, sdata;  // Serial pins
    logic               chain_out, stack_sel; // Cascade and stack flag
    logic [WIPER_W-1:0] w0, w1, ws;           // Wiper codes
    logic [16:0]        seen;                 // Bits read back
    int                 fails, tests_run;     // Counters
    dcwsp_top dut (.core_clk_i(core_clk), .rstn_i(rstn), .select_i(select), .sclk_i(sclk),
        .sdata_i(sdata), .chain_out_o(chain_out), .wiper_zero_terminal_o(w0),
        .wiper_one_terminal_o(w1), .stacked_wiper_out_o(ws), .stack_sel_o(stack_sel));
    dcwsp_ctrl_model ctrl (.core_clk_i(core_clk), .chain_out_i(chain_out), .select_o(select),
        .sclk_o(sclk), .sdata_o(sdata));
    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic t_reset();
        check({stack_sel, w1, w0}, {STACK_RST, WIPER_RST, WIPER_RST});
        check(ws, WIPER_RST);
    endtask : t_reset
    task automatic t_write(input logic s, input logic [7:0] p1, input logic [7:0] p0);
        ctrl.xfer({s, p1, p0}, 1'b0, seen);
        check({stack_sel, w1, w0}, {s, p1, p0});
        check(ws, s ? p1 : p0);
    endtask : t_write
    task automatic t_read(input logic [16:0] exp);
        ctrl.xfer(17'h00000, 1'b1, seen);
        check(seen, exp);
        check({stack_sel, w1, w0}, exp);
        check(chain_out, exp[16]);
    endtask : t_read
    task automatic t_ignore(input logic [16:0] exp);
        ctrl.idle_clocks(8);
        check(chain_out, exp[16]);
        check({stack_sel, w1, w0}, exp);
    endtask : t_ignore
    // ----------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        fails = 0;
        tests_run = 0;
        rstn = 1'b0;
        repeat (20) @(negedge core_clk);
        rstn = 1'b1;
        t_reset();
        t_write(1'b0, 8'h5A, 8'hC3);
        t_read({1'b0, 8'h5A, 8'hC3});
        t_write(1'b1, 8'h01, 8'hFE);
        t_ignore({1'b1, 8'h01, 8'hFE});
        t_read({1'b1, 8'h01, 8'hFE});
        test_done();
    end
    // Four frames need about 1000 cycles; far more means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        test_done();
    end
endmodule : dcwsp_tb_top
`default_nettype wire

// ---- logic/dcwsp_pkg.sv ----
// Operation
// - Chain output can feed next device's data input
// - Select high presents bit 0 on chain output
// - Rising clock shifts in, next bit appears out
// - Full recirculation restores original register contents
// - Select falling loads wipers and stack-select latch
// - Chain output always driven with last bit
// - Bit0 stack flag, 1-8 pot1, 9-16 pot0
// - Data sampled on clock rise while select high
// - Power-up wipers at mid-scale 1000 0000
// - Stack flag selects pot0 (0) or pot1 (1)
`default_nettype none
package dcwsp_pkg;
    // ----------------------------------------------------------
    // Shift register layout
    // ----------------------------------------------------------
    localparam int          SHIFT_LEN     = 17;        // Bits per device
    localparam int          STACK_POS     = 0;         // Stack-select flag
    localparam int          POT1_MSB_POS  = 1;         // Pot 1 MSB
    localparam int          POT0_MSB_POS  = 9;         // Pot 0 MSB
    localparam int          WIPER_W       = 8;         // Wiper code width
    // ----------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------
    localparam logic [7:0]  WIPER_RST     = 8'h80;     // Mid-scale code
    localparam logic [16:0] SHIFT_RST     = 17'h00000; // Shift reg at reset
    localparam logic        STACK_RST     = 1'h0;      // Stack flag at reset
endpackage : dcwsp_pkg
`default_nettype wire

// ---- logic/dcwsp_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Two-flop synchroniser, one per bit
// ----------------------------------------------------------
module dcwsp_sync #(
    parameter int W = 3
) (
    input  wire logic         core_clk_i, // Sampling clock
    input  wire logic         rstn_i,     // Async reset, active low
    input  wire logic [W-1:0] async_i,    // Pin levels
    output logic      [W-1:0] sync_o      // Synchronised levels
);
    logic [W-1:0] meta_q; // First stage, read only by second

    // Register both stages
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : dcwsp_sync
`default_nettype wire

// ---- logic/dcwsp_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Daisy-chain wiper shift port, device side
// ----------------------------------------------------------
module dcwsp_top
    import dcwsp_pkg::*;
#(
    parameter int LEN = SHIFT_LEN
) (
    input  wire logic               core_clk_i,            // 100 MHz core clock
    input  wire logic               rstn_i,                // Power-up reset, active low
    input  wire logic               select_i,              // Port select pin, high active
    input  wire logic               sclk_i,                // Serial clock pin
    input  wire logic               sdata_i,               // Serial data pin
    output logic                    chain_out_o,           // Cascade output
    output logic [WIPER_W-1:0]      wiper_zero_terminal_o, // Pot 0 wiper code
    output logic [WIPER_W-1:0]      wiper_one_terminal_o,  // Pot 1 wiper code
    output logic [WIPER_W-1:0]      stacked_wiper_out_o,   // Stacked wiper code
    output logic                    stack_sel_o            // Latched stack flag
);
    // ----------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------
    logic [2:0] pins_s;     // {select, clock, data} after two flops
    logic       sel_s;      // Synchronised select
    logic       clk_s;      // Synchronised serial clock
    logic       dat_s;      // Synchronised data

    dcwsp_sync #(.W(3)) u_sync (
        .core_clk_i (core_clk_i),
        .rstn_i     (rstn_i),
        .async_i    ({select_i, sclk_i, sdata_i}),
        .sync_o     (pins_s)
    );
    assign sel_s = pins_s[2];
    assign clk_s = pins_s[1];
    assign dat_s = pins_s[0];

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    logic               sel_q, sel_d;     // Previous select level
    logic               clk_q, clk_d;     // Previous clock level
    logic               rise;             // Serial clock rising edge
    logic               sel_fall;         // Select falling edge
    logic               shift_en;         // Rise seen while selected
    logic [LEN-1:0]     shr_q, shr_d;     // Shift register, index = bit position
    logic [WIPER_W-1:0] pot1_view;        // Pot 1 field, MSB first
    logic [WIPER_W-1:0] pot0_view;        // Pot 0 field, MSB first
    logic [WIPER_W-1:0] w0_q, w0_d;       // Pot 0 latch
    logic [WIPER_W-1:0] w1_q, w1_d;       // Pot 1 latch
    logic               stk_q, stk_d;     // Stack-select latch
    logic               chain_out_q, chain_out_d;   // Chain output flop
    logic [WIPER_W-1:0] stacked_wiper_out_q, stacked_wiper_out_d;   // Stacked output flop

    // ----------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------
    // Previous pin levels and the strobes derived from them
    always_comb begin
        sel_d    = sel_s;
        clk_d    = clk_s;
        rise     = clk_s & ~clk_q;
        sel_fall = sel_q & ~sel_s;
        // One synchronised select both gates edges and finds its
        // fall, so a rise and a release never race each other
        shift_en = sel_s & rise;
    end

    // Register previous levels; reset matches the idle pins,
    // so no false edge follows reset
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_q <= 1'h0;
            clk_q <= 1'h0;
        end else begin
            sel_q <= sel_d;
            clk_q <= clk_d;
        end
    end

    // ----------------------------------------------------------
    // Shift register
    // ----------------------------------------------------------
    // Bit 0 sits at the chain output end: the first bit sent, the
    // stack flag, comes to rest there and is the first bit out.
    // A loop of exactly one frame therefore rotates every bit home.
    always_comb begin
        shr_d = shr_q;
        if (shift_en) begin
            // New bit enters the top, bit 0 leaves on the chain
            shr_d = {dat_s, shr_q[LEN-1:1]};
        end else begin
            // Deselected or no rise: edges fall through untouched
            shr_d = shr_q;
        end
    end

    // Register the shift chain
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shr_q <= SHIFT_RST;
        end else begin
            shr_q <= shr_d;
        end
    end

    // ----------------------------------------------------------
    // Field views
    // ----------------------------------------------------------
    // Each wiper field is stored MSB first from its lowest index;
    // one loop maps every bit of both fields
    for (genvar g = 0; g < WIPER_W; g++) begin : g_field
        assign pot1_view[WIPER_W-1-g] = shr_q[POT1_MSB_POS+g];
        assign pot0_view[WIPER_W-1-g] = shr_q[POT0_MSB_POS+g];
    end

    // ----------------------------------------------------------
    // Wiper and stack latches
    // ----------------------------------------------------------
    // Load only on select release, so a frame still in flight
    // never moves a wiper; a cut frame loads whatever it left
    always_comb begin
        w0_d  = w0_q;
        w1_d  = w1_q;
        stk_d = stk_q;
        if (sel_fall) begin
            // Release: take all three fields at once
            stk_d = shr_q[STACK_POS];
            w1_d  = pot1_view;
            w0_d  = pot0_view;
        end
    end

    // Register the latches; both wipers start at mid-scale
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w0_q  <= WIPER_RST;
            w1_q  <= WIPER_RST;
            stk_q <= STACK_RST;
        end else begin
            w0_q  <= w0_d;
            w1_q  <= w1_d;
            stk_q <= stk_d;
        end
    end

    // ----------------------------------------------------------
    // Output stage
    // ----------------------------------------------------------
    // Outputs come from next values so they move with their source
    always_comb begin
        // Last bit is always on the chain pin, selected or not
        chain_out_d = shr_d[0];
        // Stack flag picks which wiper reaches the stacked output
        stacked_wiper_out_d = stk_d ? w1_d : w0_d;
    end

    // Register the outputs; reset values agree with their sources
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chain_out_q <= SHIFT_RST[0];
            stacked_wiper_out_q <= WIPER_RST;
        end else begin
            chain_out_q <= chain_out_d;
            stacked_wiper_out_q <= stacked_wiper_out_d;
        end
    end

    assign chain_out_o           = chain_out_q;
    assign wiper_zero_terminal_o = w0_q;
    assign wiper_one_terminal_o  = w1_q;
    assign stacked_wiper_out_o   = stacked_wiper_out_q;
    assign stack_sel_o           = stk_q;

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    // Shift strobe as the logic sees it
    sequence s_shift_edge;
        sel_s && clk_s && !clk_q;
    endsequence

    // Select released after a frame
    sequence s_sel_fall;
        sel_q && !sel_s;
    endsequence

    // Select raised with no clock rise in the same cycle
    sequence s_sel_rise_quiet;
        $rose(sel_s) && !(clk_s && !clk_q);
    endsequence

    AST_SHIFT_IN: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_shift_edge |=> shr_q[LEN-1] == $past(dat_s) && shr_q[0] == $past(shr_q[1]))
        else $error("shift did not take data");
    AST_CHAIN_OUT_TRACK: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        chain_out_o == shr_q[0])
        else $error("chain out not last bit");
    AST_IDLE_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !sel_s && !sel_q |=> $stable(shr_q) && $stable(w0_q) && $stable(w1_q)
            && $stable(stk_q))
        else $error("state changed while deselected");
    AST_LATCH: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_sel_fall |=> stk_q == $past(shr_q[STACK_POS])
            && w0_q[WIPER_W-1] == $past(shr_q[POT0_MSB_POS])
            && w1_q[WIPER_W-1] == $past(shr_q[POT1_MSB_POS]))
        else $error("latch on select fall failed");
    AST_STACK_MUX: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        stacked_wiper_out_o == (stk_q ? w1_q : w0_q))
        else $error("stacked output mismatch");
    AST_NO_SHIFT_LOW: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        !sel_s |=> shr_q == $past(shr_q))
        else $error("shift while select low");
    AST_POT1_LSB: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_sel_fall |=> w1_q[0] == $past(shr_q[POT1_MSB_POS+WIPER_W-1]))
        else $error("pot1 lsb misplaced");
    AST_POT0_LSB: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_sel_fall |=> w0_q[0] == $past(shr_q[POT0_MSB_POS+WIPER_W-1]))
        else $error("pot0 lsb misplaced");
    AST_CHAIN_OUT_SELECT: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        s_sel_rise_quiet |-> chain_out_o == shr_q[0])
        else $error("last bit not shown on select");
    AST_WIPER_HOLD: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        sel_s |=> $stable(w0_q) && $stable(w1_q) && $stable(stk_q))
        else $error("wiper moved while selected");
endmodule : dcwsp_top
`default_nettype wire
